// file: src/return_and_rotate_exec.sv
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rstn,
  // decoded instruction
  input  wire logic                           opValid,
  input  wire ret_rot_pkg::op_e               opCode,
  input  wire logic [ret_rot_pkg::DATA_W-1:0] literal,
  input  wire logic [ret_rot_pkg::ADDR_W-1:0] fileAddr,
  input  wire logic                           destSel,
  // return stack top entry and file read data
  input  wire logic [ret_rot_pkg::PC_W-1:0]   stackTopEntry,
  input  wire logic [ret_rot_pkg::DATA_W-1:0] fileRdata,
  // file write port
  output logic                                fileWe,
  output logic      [ret_rot_pkg::ADDR_W-1:0] fileWaddr,
  output logic      [ret_rot_pkg::DATA_W-1:0] fileWdata,
  // architectural state
  output logic      [ret_rot_pkg::PC_W-1:0]   programCounter,
  output logic      [ret_rot_pkg::DATA_W-1:0] workReg,
  output logic                                carryFlag,
  output logic      [ret_rot_pkg::DATA_W-1:0] interruptControlReg,
  output logic      [ret_rot_pkg::SP_W-1:0]   stackPtr,
  // pipeline status
  output logic                                flushCycle,
  output logic                                busy
);
  import ret_rot_pkg::*;

  logic [PC_W-1:0]   pc_r;
  logic [DATA_W-1:0] wreg_r;
  logic              carry_r;
  logic [DATA_W-1:0] icr_r;
  logic [SP_W-1:0]   sp_r;
  logic              flush_r;
  logic              we_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rotRes;
  logic              rotCarry;
  logic              take;
  logic              isRet;
  logic              isRot;

  // shared decode: every return pops, only the rotate and the literal return write data
  function automatic logic isReturnOp(input op_e op);
    return (op == OP_RETURN_FROM_INTERRUPT) || (op == OP_RETURN) ||
           (op == OP_RETURN_WITH_LITERAL);
  endfunction

  function automatic logic isRotateOp(input op_e op);
    return op == OP_ROTATE_LEFT_CARRY;
  endfunction

  // instructions arriving during the flush slot are ignored; fetch is discarded
  assign take  = opValid && !flush_r;
  assign isRet = take && isReturnOp(opCode);
  assign isRot = take && isRotateOp(opCode);

  rotate_left_unit uRot (
    .srcVal   (fileRdata),
    .carryIn  (carry_r),
    .result   (rotRes),
    .carryOut (rotCarry)
  );

  // program counter: pops load stack top, rotate advances
  // a no-op or refused fetch leaves it, so a stray valid costs nothing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= PC_RST;
    end else if (isRet) begin
      pc_r <= stackTopEntry;
    end else if (isRot) begin
      pc_r <= pc_r + PC_ONE;
    end
  end

  // stack pointer: one decrement per pop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sp_r <= SP_RST;
    end else if (isRet) begin
      sp_r <= sp_r - SP_ONE;
    end
  end

  // second cycle of every return is a flushed no-op
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= isRet;
    end
  end

  // global interrupt enable set by interrupt return
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      icr_r <= ICR_RST;
    end else if (isRet && opCode == OP_RETURN_FROM_INTERRUPT) begin
      icr_r[GIE_BIT] <= 1'b1;
    end
  end

  // working register: literal load or rotate result
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wreg_r <= WREG_RST;
    end else if (take && opCode == OP_RETURN_WITH_LITERAL) begin
      wreg_r <= literal;
    end else if (isRot && destSel == DEST_WORK) begin
      wreg_r <= rotRes;
    end
  end

  // carry: only rotate touches it; returns leave flags alone
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      carry_r <= 1'b0;
    end else if (isRot) begin
      carry_r <= rotCarry;
    end
  end

  // file write-back, registered one cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      we_r    <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else begin
      we_r <= isRot && destSel == DEST_FILE;
      if (isRot) begin
        waddr_r <= fileAddr;
        wdata_r <= rotRes;
      end
    end
  end

  assign programCounter      = pc_r;
  assign workReg             = wreg_r;
  assign carryFlag           = carry_r;
  assign interruptControlReg = icr_r;
  assign stackPtr            = sp_r;
  assign flushCycle          = flush_r;
  assign busy                = flush_r;
  assign fileWe              = we_r;
  assign fileWaddr           = waddr_r;
  assign fileWdata           = wdata_r;

  sequence s_retTaken;
    isRet;
  endsequence

  AST_RET_PC: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_retTaken |=> (pc_r == $past(stackTopEntry)))
    else $error("return did not load pc from stack top");
  AST_GIE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isRet && opCode == OP_RETURN_FROM_INTERRUPT) |=> icr_r[GIE_BIT])
    else $error("interrupt return did not set enable");
  AST_RET_NOFLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_retTaken |=> $stable(carry_r))
    else $error("return changed carry");
  AST_RETURN_WITH_LITERAL_OP_W: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isRet && opCode == OP_RETURN_WITH_LITERAL) |=> (wreg_r == $past(literal)))
    else $error("literal return bad working register");
  AST_ROT_C: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && opCode == OP_ROTATE_LEFT_CARRY) |=> (carry_r == $past(fileRdata[DATA_W-1])))
    else $error("rotate carry wrong");
  AST_ROT_DEST: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && opCode == OP_ROTATE_LEFT_CARRY && destSel == DEST_FILE) |=>
      (we_r && wdata_r == {$past(fileRdata[DATA_W-2:0]), $past(carry_r)}))
    else $error("rotate write-back wrong");
  AST_ROT_ONE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && opCode == OP_ROTATE_LEFT_CARRY) |=> (!flush_r && pc_r == $past(pc_r) + PC_ONE))
    else $error("rotate not single cycle");
  AST_SP_FLUSH: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_retTaken |=> (flush_r && sp_r == $past(sp_r) - SP_ONE) ##1 !flush_r)
    else $error("pop or flush wrong");

  // the flush slot: fetch discarded, nothing architectural moves
  sequence s_flushSlot;
    flush_r;
  endsequence

  // slot open again for the next fetch
  sequence s_slotFree;
    !flush_r;
  endsequence

  // a rotate accepted this cycle
  sequence s_rotTaken;
    take && opCode == OP_ROTATE_LEFT_CARRY;
  endsequence

  // interrupt return spends exactly one flushed slot, then frees it
  AST_RETURN_FROM_INTERRUPT_OP_TWO: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isRet && opCode == OP_RETURN_FROM_INTERRUPT) |=> s_flushSlot ##1 s_slotFree)
    else $error("interrupt return not two cycles");
  AST_RET_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isRet && opCode == OP_RETURN) |=> ($stable(wreg_r) && $stable(icr_r) && !we_r))
    else $error("plain return touched other state");
  AST_RETURN_WITH_LITERAL_OP_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isRet && opCode == OP_RETURN_WITH_LITERAL) |=>
      ($stable(carry_r) && pc_r == $past(stackTopEntry) && !we_r))
    else $error("literal return changed a flag or pc");
  AST_ROT_FLAGS: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_rotTaken |=> ($stable(icr_r) && $stable(sp_r)))
    else $error("rotate touched more than carry");
  AST_ROT_WORK: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && opCode == OP_ROTATE_LEFT_CARRY && destSel == DEST_WORK) |=>
      (!we_r && wreg_r == {$past(fileRdata[DATA_W-2:0]), $past(carry_r)}))
    else $error("rotate to working register wrong");
  AST_ROT_KEEP_W: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && opCode == OP_ROTATE_LEFT_CARRY && destSel == DEST_FILE) |=>
      ($stable(wreg_r) && waddr_r == $past(fileAddr)))
    else $error("rotate to file disturbed working register");
  AST_NONE_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && opCode == OP_NONE) |=> ($stable(pc_r) && $stable(wreg_r) && !we_r))
    else $error("no-op advanced state");

  // a fetch offered in the flush slot is dropped without side effects
  AST_FLUSH_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_flushSlot |=> ($stable(pc_r) && $stable(sp_r) && $stable(wreg_r) &&
                     $stable(carry_r) && !we_r && !flush_r))
    else $error("flushed cycle changed state");
endmodule
`default_nettype wire

// file: src/ret_rot_pkg.sv
// Function
// - interrupt return pops stack, loads program counter
// - interrupt return sets global interrupt enable
// - plain return pops stack, no flags changed
// - literal return loads working register, pops stack
// - rotate left through carry, carry only
// - destination bit picks working or source register
// - seven-bit address, one word; rotate one cycle, returns two
package ret_rot_pkg;
  localparam int PC_W        = 15;
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int SP_W        = 4;
  localparam int GIE_BIT     = 7;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
  localparam logic [DATA_W-1:0] ICR_RST  = 8'h00;
  localparam logic [SP_W-1:0] SP_RST     = 4'hF;
  localparam logic [SP_W-1:0] SP_ONE     = 4'h1;
  localparam logic [PC_W-1:0] PC_ONE     = 15'h0001;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RETURN_FROM_INTERRUPT,
    OP_RETURN,
    OP_RETURN_WITH_LITERAL,
    OP_ROTATE_LEFT_CARRY
  } op_e;
endpackage

// file: src/rotate_left_unit.sv
`timescale 1ns/1ns
`default_nettype none
module rotate_left_unit (
  // operand and carry in
  input  wire logic [ret_rot_pkg::DATA_W-1:0] srcVal,
  input  wire logic                           carryIn,
  // result and carry out
  output logic      [ret_rot_pkg::DATA_W-1:0] result,
  output logic                                carryOut
);
  import ret_rot_pkg::*;
  // old carry enters bit 0, old msb leaves as carry
  assign result   = {srcVal[DATA_W-2:0], carryIn};
  assign carryOut = srcVal[DATA_W-1];
endmodule
`default_nettype wire

// file: sim/test_return_and_rotate_exec.sv
`timescale 1ns/1ns
`default_nettype none
module test_return_and_rotate_exec;
  import ret_rot_pkg::*;
  typedef struct {op_e o; logic [7:0] k; logic [6:0] a; logic d; logic [14:0] t; logic [7:0] rd;
    logic [14:0] pc; logic [7:0] w; logic c; logic [3:0] sp;} row_s;
  logic        ref_clk, rstn, opValid, destSel, fileWe, carryFlag, flushCycle, busy;
  op_e         opCode;
  logic [7:0]  literal, fileRdata, fileWdata, workReg, interruptControlReg;
  logic [6:0]  fileAddr, fileWaddr;
  logic [14:0] stackTopEntry, programCounter;
  logic [3:0]  stackPtr;
  logic        global_irq_enable_bit = 1'b0;
  int          num_errors = 0, checks = 0;
  // the no-op row proves a stray valid does not step the counter
  row_s        rows [7] = '{
    '{OP_ROTATE_LEFT_CARRY, 8'h00, 7'h05, 1'b0, 15'h0000, 8'hE6, 15'h0001, 8'hCC, 1'b1, 4'hF},
    '{OP_NONE, 8'h00, 7'h00, 1'b0, 15'h0000, 8'h00, 15'h0001, 8'hCC, 1'b1, 4'hF},
    '{OP_ROTATE_LEFT_CARRY, 8'h00, 7'h7F, 1'b1, 15'h0000, 8'h80, 15'h0002, 8'hCC, 1'b1, 4'hF},
    '{OP_RETURN, 8'h00, 7'h00, 1'b0, 15'h1234, 8'h00, 15'h1234, 8'hCC, 1'b1, 4'hE},
    '{OP_RETURN_WITH_LITERAL, 8'hFF, 7'h00, 1'b0, 15'h0ABC, 8'h00, 15'h0ABC, 8'hFF, 1'b1, 4'hD},
    '{OP_RETURN_FROM_INTERRUPT, 8'h00, 7'h00, 1'b0, 15'h7FFF, 8'h00, 15'h7FFF, 8'hFF, 1'b1, 4'hC},
    '{OP_ROTATE_LEFT_CARRY, 8'h00, 7'h00, 1'b0, 15'h0000, 8'h00, 15'h0000, 8'h01, 1'b0, 4'hC}};

  return_and_rotate_exec return_and_rotate_exec_i (.ref_clk, .rstn, .opValid, .opCode, .literal, .fileAddr,
    .destSel, .stackTopEntry, .fileRdata, .fileWe, .fileWaddr, .fileWdata, .programCounter, .workReg,
    .carryFlag, .interruptControlReg, .stackPtr, .flushCycle, .busy);

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %0h seen %0h", n, e, s);
    end
  endtask

  task automatic st(input logic [14:0] pc, input logic [7:0] w, input logic c, input logic [3:0] sp);
    chk("pc", {1'b0, programCounter}, {1'b0, pc});
    chk("w", {8'h00, workReg}, {8'h00, w});
    chk("c", {15'h0000, carryFlag}, {15'h0000, c});
    chk("sp", {12'h000, stackPtr}, {12'h000, sp});
  endtask

  task automatic drv(input op_e o, input logic [6:0] a, input logic d, input logic [14:0] t, input logic [7:0] rd);
    opCode = o;
    fileAddr = a;
    destSel = d;
    stackTopEntry = t;
    fileRdata = rd;
  endtask

  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // bounded wait for the flushed cycle to end
  task automatic waitIdle;
    repeat (4) if (flushCycle !== 1'b0) @(negedge ref_clk);
    if (flushCycle !== 1'b0) begin
      num_errors++;
      test_done;
    end
  endtask

  // table rows first, then the awkward cases by hand
  initial begin
    rstn = 1'b0;
    opValid = 1'b0;
    literal = 8'h00;
    drv(OP_NONE, 7'h00, 1'b0, 15'h0000, 8'h00);
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    foreach (rows[i]) begin
      @(negedge ref_clk);
      drv(rows[i].o, rows[i].a, rows[i].d, rows[i].t, rows[i].rd);
      literal = rows[i].k;
      opValid = 1'b1;
      @(negedge ref_clk);
      opValid = 1'b0;
      global_irq_enable_bit = global_irq_enable_bit | (rows[i].o == OP_RETURN_FROM_INTERRUPT);
      st(rows[i].pc, rows[i].w, rows[i].c, rows[i].sp);
      chk("gie", {15'h0000, interruptControlReg[7]}, {15'h0000, global_irq_enable_bit});
      chk("we", {15'h0000, fileWe}, {15'h0000, rows[i].o == OP_ROTATE_LEFT_CARRY && rows[i].d});
      if (fileWe === 1'b1) chk("wr", {1'b0, fileWaddr, fileWdata}, {1'b0, rows[i].a, 8'h01});
      chk("flush", {15'h0000, flushCycle}, {15'h0000, rows[i].o inside {OP_RETURN, OP_RETURN_WITH_LITERAL,
        OP_RETURN_FROM_INTERRUPT}});
      chk("busy", {15'h0000, busy}, {15'h0000, rows[i].o inside {OP_RETURN, OP_RETURN_WITH_LITERAL,
        OP_RETURN_FROM_INTERRUPT}});
      waitIdle;
    end
    // a rotate held through the flushed cycle must wait, then run back to back
    @(negedge ref_clk);
    drv(OP_RETURN, 7'h00, 1'b0, 15'h0055, 8'h00);
    opValid = 1'b1;
    @(negedge ref_clk);
    drv(OP_ROTATE_LEFT_CARRY, 7'h01, 1'b0, 15'h0000, 8'h0F);
    @(negedge ref_clk);
    st(15'h0055, 8'h01, 1'b0, 4'hB);
    @(negedge ref_clk);
    drv(OP_ROTATE_LEFT_CARRY, 7'h03, 1'b1, 15'h0000, 8'h81);
    st(15'h0056, 8'h1E, 1'b0, 4'hB);
    @(negedge ref_clk);
    opValid = 1'b0;
    st(15'h0057, 8'h1E, 1'b1, 4'hB);
    chk("wr", {fileWe, fileWaddr, fileWdata}, 16'h8302);
    // reset in mid-run
    rstn = 1'b0;
    @(negedge ref_clk);
    st(15'h0000, 8'h00, 1'b0, 4'hF);
    chk("icr", {8'h00, interruptControlReg}, 16'h0000);
    // first fetch right at the first edge after release must be taken
    rstn = 1'b1;
    drv(OP_ROTATE_LEFT_CARRY, 7'h02, 1'b0, 15'h0000, 8'h81);
    opValid = 1'b1;
    @(negedge ref_clk);
    opValid = 1'b0;
    st(15'h0001, 8'h02, 1'b1, 4'hF);
    chk("busy", {15'h0000, busy}, 16'h0000);
    test_done;
  end
endmodule
`default_nettype wire
